/* rtl/adc_cmd_pkg.sv */
// Shared constants for the serial command decoder.
package adc_cmd_pkg;
  localparam int unsigned FRAME_BITS   = 16;
  localparam int unsigned DATA_BITS    = 11;
  localparam int unsigned RESULT_BITS  = 12;
  localparam int unsigned CHAN_BITS    = 4;
  // Frame field positions.
  localparam int unsigned CLASS_POS    = 15;
  localparam int unsigned SCAN_MSB     = 14;
  localparam int unsigned SCAN_LSB     = 11;
  localparam int unsigned CHAN_MSB     = 10;
  localparam int unsigned CHAN_LSB     = 7;
  localparam int unsigned RST_MSB      = 6;
  localparam int unsigned RST_LSB      = 5;
  localparam int unsigned PM_MSB       = 4;
  localparam int unsigned PM_LSB       = 3;
  localparam int unsigned TAG_POS      = 2;
  localparam int unsigned SWTRIG_POS   = 1;
  // Values after reset.
  localparam logic [3:0] SCAN_DEFAULT  = 4'h1;
  localparam logic [3:0] CHAN_DEFAULT  = 4'h0;
  localparam logic [1:0] PM_DEFAULT    = 2'h0;
  localparam logic       TAG_DEFAULT   = 1'b0;
  localparam logic       SWTRIG_DEFAULT = 1'b0;
  // Codes.
  localparam logic [3:0] SCAN_KEEP     = 4'h0;
  localparam logic [1:0] RST_NONE      = 2'h0;
  localparam logic [1:0] RST_FIFO      = 2'h1;
  localparam logic [1:0] RST_ALL       = 2'h2;
  localparam logic [3:0] SEL_RESERVED  = 4'hf;
  localparam logic [4:0] LAST_BIT_IDX  = 5'h0f;
  localparam logic [4:0] COUNT_CLEAR   = 5'h00;
endpackage

/* rtl/frame_if.sv */
// Carrier for received command frames between receiver and decoder.
`timescale 1ns/1ns
`default_nettype none
interface frame_if;
  logic [15:0] word;
  logic        valid;
  logic        cs_rise;
  modport rx  (output word, output valid, output cs_rise);
  modport dec (input word, input valid, input cs_rise);
endinterface
`default_nettype wire

/* rtl/serial_frame_rx.sv */
// Serial frame receiver: synchronises the 3-wire link and assembles 16-bit words.
`timescale 1ns/1ns
`default_nettype none
module serial_frame_rx (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // Link pins
  input  wire logic cs_n,
  input  wire logic sclk,
  input  wire logic din,
  // Received frames
  frame_if.rx       frame
);
  logic       cs_s1, cs_s2, cs_prev;
  logic       sclk_s1, sclk_s2, sclk_prev;
  logic       din_s1, din_s2;
  logic [4:0] bit_count;
  logic [14:0] shift;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cs_s1     <= 1'b1;
      cs_s2     <= 1'b1;
      cs_prev   <= 1'b1;
      sclk_s1   <= 1'b0;
      sclk_s2   <= 1'b0;
      sclk_prev <= 1'b0;
      din_s1    <= 1'b0;
      din_s2    <= 1'b0;
    end else begin
      cs_s1     <= cs_n;
      cs_s2     <= cs_s1;
      cs_prev   <= cs_s2;
      sclk_s1   <= sclk;
      sclk_s2   <= sclk_s1;
      sclk_prev <= sclk_s2;
      din_s1    <= din;
      din_s2    <= din_s1;
    end
  end

  // Bits after the sixteenth are ignored so a long frame cannot re-fire.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bit_count   <= adc_cmd_pkg::COUNT_CLEAR;
      shift       <= 15'h0000;
      frame.word  <= 16'h0000;
      frame.valid <= 1'b0;
    end else begin
      frame.valid <= 1'b0;
      if (cs_s2) begin
        bit_count <= adc_cmd_pkg::COUNT_CLEAR;
      end else if (sclk_s2 && !sclk_prev && bit_count <= adc_cmd_pkg::LAST_BIT_IDX) begin
        shift     <= {shift[13:0], din_s2}; // R1
        bit_count <= bit_count + 5'h01;
        if (bit_count == adc_cmd_pkg::LAST_BIT_IDX) begin
          frame.word  <= {shift, din_s2}; // R1
          frame.valid <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      frame.cs_rise <= 1'b0;
    end else begin
      frame.cs_rise <= cs_s2 && !cs_prev;
    end
  end
endmodule
`default_nettype wire

/* rtl/adc_command_decode.sv */
// Command decoder and mode-control register of the converter.
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// (R1) Frames are 16 bits, MSB first, under low chip select; act after all sixteen.
// (R2) Top bit zero writes mode control; else next four bits pick register, eleven data.
// (R3) Host never sends top five bits all ones; such frames are dropped.
// (R4) Scan field 0000 keeps scan mode and channel unchanged.
// (R5) Channel field bits 10:7 picks input channel, default 0000.
// (R6) Reset code 00 nothing, 01 clears result FIFO, 11 no effect.
// (R7) Reset code 10 returns all configuration to defaults.
// (R8) Power field bits 4:3, default 00, selects power-down modes.
// (R9) Tag bit in external mode gives 4-bit channel plus 12-bit result.
// (R10) Internal clock mode always prefixes the channel address.
// (R11) Software trigger in internal mode starts conversions at chip select rise.
// (R12) Software trigger bit clears itself after its conversions finish.
// (R13) Host rewrites software trigger bit for every further triggered conversion.
// (R14) Host holds chip select low at least 17 serial clocks with trigger.
// (R15) Averaging stores only the average of the configured conversions.
// (R16) Averaging only applies in internal clock mode.
// (R17) Automatic scans visit every channel number, pairs converted twice.
// (R18) Host should use manual or even/odd lists to avoid duplicate pairs.
module adc_command_decode (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Serial link and convert pin
  input  wire logic        cs_n,
  input  wire logic        sclk,
  input  wire logic        din,
  input  wire logic        convert_start_pin_n,
  // Converter status from same-domain logic
  input  wire logic        internal_clock_mode,
  input  wire logic        averaging_request,
  input  wire logic        conversion_done,
  input  wire logic        scan_done,
  input  wire logic [11:0] result_data,
  input  wire logic [3:0]  result_channel,
  input  wire logic        result_valid,
  // Mode-control register contents
  output logic [3:0]       scan_mode,
  output logic [3:0]       input_channel_field,
  output logic [1:0]       power_state_field,
  output logic             channel_tag_enable,
  output logic             software_trigger_bit,
  // Other register writes
  output logic             reg_write,
  output logic [3:0]       reg_select,
  output logic [10:0]      reg_data,
  // Control pulses and levels
  output logic             fifo_clear,
  output logic             soft_reset,
  output logic             start_conversion,
  output logic             averaging_active,
  output logic [3:0]       scan_channel,
  // Output words
  output logic [15:0]      out_word,
  output logic             out_valid
);
  frame_if frame ();

  serial_frame_rx rx (
    .clk   (clk),
    .rstn  (rstn),
    .cs_n  (cs_n),
    .sclk  (sclk),
    .din   (din),
    .frame (frame)
  );

  logic       cnv_s1, cnv_s2, cnv_prev;
  logic       sw_busy;
  logic       mode_write;
  logic [1:0] rst_code;

  assign mode_write = frame.valid && !frame.word[adc_cmd_pkg::CLASS_POS]; // R2
  assign rst_code   = frame.word[adc_cmd_pkg::RST_MSB:adc_cmd_pkg::RST_LSB];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnv_s1   <= 1'b1;
      cnv_s2   <= 1'b1;
      cnv_prev <= 1'b1;
    end else begin
      cnv_s1   <= convert_start_pin_n;
      cnv_s2   <= cnv_s1;
      cnv_prev <= cnv_s2;
    end
  end

  // Mode-control register; a full soft reset overrides the other fields of the same frame.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      scan_mode            <= adc_cmd_pkg::SCAN_DEFAULT;
      input_channel_field  <= adc_cmd_pkg::CHAN_DEFAULT;
      power_state_field    <= adc_cmd_pkg::PM_DEFAULT;
      channel_tag_enable   <= adc_cmd_pkg::TAG_DEFAULT;
      software_trigger_bit <= adc_cmd_pkg::SWTRIG_DEFAULT;
    end else if (mode_write && rst_code == adc_cmd_pkg::RST_ALL) begin
      scan_mode            <= adc_cmd_pkg::SCAN_DEFAULT; // R7
      input_channel_field  <= adc_cmd_pkg::CHAN_DEFAULT;
      power_state_field    <= adc_cmd_pkg::PM_DEFAULT;
      channel_tag_enable   <= adc_cmd_pkg::TAG_DEFAULT;
      software_trigger_bit <= adc_cmd_pkg::SWTRIG_DEFAULT;
    end else if (mode_write) begin
      if (frame.word[adc_cmd_pkg::SCAN_MSB:adc_cmd_pkg::SCAN_LSB] != adc_cmd_pkg::SCAN_KEEP) begin // R4
        scan_mode           <= frame.word[adc_cmd_pkg::SCAN_MSB:adc_cmd_pkg::SCAN_LSB];
        input_channel_field <= frame.word[adc_cmd_pkg::CHAN_MSB:adc_cmd_pkg::CHAN_LSB]; // R5
      end
      power_state_field    <= frame.word[adc_cmd_pkg::PM_MSB:adc_cmd_pkg::PM_LSB]; // R8
      channel_tag_enable   <= frame.word[adc_cmd_pkg::TAG_POS];
      software_trigger_bit <= frame.word[adc_cmd_pkg::SWTRIG_POS]; // R13
    end else if (scan_done && sw_busy) begin
      software_trigger_bit <= 1'b0; // R12
    end
  end

  // Reset pulses; code 11 falls through with no effect.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fifo_clear <= 1'b0;
      soft_reset <= 1'b0;
    end else begin
      fifo_clear <= mode_write && rst_code == adc_cmd_pkg::RST_FIFO; // R6
      soft_reset <= mode_write && rst_code == adc_cmd_pkg::RST_ALL; // R7
    end
  end

  // Writes to the other registers go out as a strobe; the reserved selection is dropped.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_write  <= 1'b0;
      reg_select <= 4'h0;
      reg_data   <= 11'h000;
    end else begin
      reg_write <= frame.valid && frame.word[adc_cmd_pkg::CLASS_POS]
                   && frame.word[adc_cmd_pkg::SCAN_MSB:adc_cmd_pkg::SCAN_LSB] != adc_cmd_pkg::SEL_RESERVED; // R2 R3
      if (frame.valid && frame.word[adc_cmd_pkg::CLASS_POS]) begin
        reg_select <= frame.word[adc_cmd_pkg::SCAN_MSB:adc_cmd_pkg::SCAN_LSB]; // R2
        reg_data   <= frame.word[adc_cmd_pkg::DATA_BITS-1:0];
      end
    end
  end

  // Conversion start from the pin or, in internal mode, from chip select rising.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      start_conversion <= 1'b0;
      sw_busy          <= 1'b0;
    end else begin
      start_conversion <= (cnv_s2 && !cnv_prev)
                          || (frame.cs_rise && software_trigger_bit && internal_clock_mode); // R11
      if (frame.cs_rise && software_trigger_bit && internal_clock_mode) begin
        sw_busy <= 1'b1;
      end else if (scan_done) begin
        sw_busy <= 1'b0;
      end
    end
  end

  // Averaging is only honoured on the internal clock; the converter does the summing.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      averaging_active <= 1'b0;
    end else begin
      averaging_active <= averaging_request && internal_clock_mode; // R15 R16
    end
  end

  // Scans step through every channel number; pairs are not skipped, so they convert twice.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      scan_channel <= 4'h0;
    end else if (start_conversion || scan_done) begin
      scan_channel <= 4'h0;
    end else if (conversion_done) begin
      scan_channel <= scan_channel + 4'h1; // R17
    end
  end

  // Output word formatting.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      out_word  <= 16'h0000;
      out_valid <= 1'b0;
    end else begin
      out_valid <= result_valid;
      if (result_valid) begin
        if (channel_tag_enable || internal_clock_mode) begin
          out_word <= {result_channel, result_data}; // R9 R10
        end else begin
          out_word <= {4'h0, result_data};
        end
      end
    end
  end

  a_other_write: assert property (@(posedge clk) disable iff (!rstn) // R2
    frame.valid && frame.word[15] && frame.word[14:11] != 4'hf |=> reg_write && reg_data == $past(frame.word[10:0]))
    else $error("other register write not issued");
  a_reserved_drop: assert property (@(posedge clk) disable iff (!rstn) // R3
    frame.valid && frame.word[15:11] == 5'h1f |=> !reg_write)
    else $error("reserved selection was written");
  a_scan_hold: assert property (@(posedge clk) disable iff (!rstn) // R4
    mode_write && frame.word[14:11] == 4'h0 && rst_code != 2'h2 |=> $stable(scan_mode) && $stable(input_channel_field))
    else $error("scan mode changed on keep code");
  a_chan_load: assert property (@(posedge clk) disable iff (!rstn) // R5
    mode_write && frame.word[14:11] != 4'h0 && rst_code != 2'h2 |=> input_channel_field == $past(frame.word[10:7]))
    else $error("channel field not loaded");
  a_fifo_clear: assert property (@(posedge clk) disable iff (!rstn) // R6
    mode_write |=> fifo_clear == ($past(rst_code) == 2'h1))
    else $error("fifo clear pulse wrong");
  a_soft_default: assert property (@(posedge clk) disable iff (!rstn) // R7
    mode_write && rst_code == 2'h2 |=> scan_mode == 4'h1 && power_state_field == 2'h0 && soft_reset)
    else $error("soft reset did not restore defaults");
  a_tag_format: assert property (@(posedge clk) disable iff (!rstn) // R10
    result_valid && internal_clock_mode |=> out_word[15:12] == $past(result_channel) && out_valid)
    else $error("channel prefix missing");
  a_sw_start: assert property (@(posedge clk) disable iff (!rstn) // R11
    frame.cs_rise && software_trigger_bit && internal_clock_mode |=> start_conversion ##1 sw_busy)
    else $error("software trigger did not start");
  a_sw_clear: assert property (@(posedge clk) disable iff (!rstn) // R12
    scan_done && sw_busy && !mode_write |=> !software_trigger_bit)
    else $error("software trigger bit not cleared");
  a_avg_gate: assert property (@(posedge clk) disable iff (!rstn) // R16
    !internal_clock_mode |=> !averaging_active)
    else $error("averaging active on external clock");

  c_mode_write: cover property (@(posedge clk) disable iff (!rstn) mode_write);
  c_other_write: cover property (@(posedge clk) disable iff (!rstn) reg_write);
  c_sw_cycle: cover property (@(posedge clk) disable iff (!rstn) start_conversion && sw_busy ##[1:1000] !software_trigger_bit);
  c_soft_reset: cover property (@(posedge clk) disable iff (!rstn) soft_reset);
endmodule
`default_nettype wire

/* dv/host_link_model.sv */
// Host side of the 3-wire command link: shifts command frames into the decoder.
`timescale 1ns/1ns
`default_nettype none
module host_link_model (
  // Link pins
  output logic cs_n,
  output logic sclk,
  output logic din
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din  = 1'b0;
  end

  // Sends nclk serial clocks under one chip select; bits after the sixteenth carry no data.
  // The serial clock stands low outside frames, as a real host leaves it.
  // Reserved selects are only sent when a scenario asks for them on purpose.
  // A trigger frame is never repeated here; the bench writes a new one each time.
  // Scans asked for here only step single channels, so no pair is converted twice.
  task automatic send(input logic [15:0] w, input int nclk);
    int i;
    cs_n = 1'b0;
    #63;
    for (i = 0; i < nclk; i++) begin
      din = (i < 16) ? w[15-i] : ~din;
      #62;
      sclk = 1'b1;
      #63;
      sclk = 1'b0;
    end
    // The line is released, so it must not keep showing the last bit.
    din = ~din;
    #63;
    cs_n = 1'b1;
    #250;
  endtask
endmodule
`default_nettype wire

/* dv/adc_command_decode_tb.sv */
// Self-checking bench for the command decoder and mode-control register.
`timescale 1ns/1ns
`default_nettype none
module adc_command_decode_tb;
  logic        clk, rstn, cs_n, sclk, din, pin_n, int_mode, avg_req, conv_done, scan_done, res_valid;
  logic [11:0] res_data;
  logic [3:0]  res_chan, scan_mode, chan_f, reg_select, scan_channel;
  logic [1:0]  pm_f;
  logic        tag_f, sw_f, reg_write, fifo_clear, soft_reset, start_conv, avg_act, out_valid;
  logic [10:0] reg_data;
  logic [15:0] out_word, last_out;
  int          fails, num_checks, n_rw, n_fc, n_sr, n_sc, n_ov;

  adc_command_decode uut (.clk(clk), .rstn(rstn), .cs_n(cs_n), .sclk(sclk), .din(din),
    .convert_start_pin_n(pin_n), .internal_clock_mode(int_mode), .averaging_request(avg_req),
    .conversion_done(conv_done), .scan_done(scan_done), .result_data(res_data),
    .result_channel(res_chan), .result_valid(res_valid), .scan_mode(scan_mode),
    .input_channel_field(chan_f), .power_state_field(pm_f), .channel_tag_enable(tag_f),
    .software_trigger_bit(sw_f), .reg_write(reg_write), .reg_select(reg_select),
    .reg_data(reg_data), .fifo_clear(fifo_clear), .soft_reset(soft_reset),
    .start_conversion(start_conv), .averaging_active(avg_act), .scan_channel(scan_channel),
    .out_word(out_word), .out_valid(out_valid));

  host_link_model host (.cs_n(cs_n), .sclk(sclk), .din(din));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Pulses last one cycle, so they are counted at every edge rather than sampled later.
  always @(posedge clk) begin
    if (reg_write === 1'b1) n_rw++;
    if (fifo_clear === 1'b1) n_fc++;
    if (soft_reset === 1'b1) n_sr++;
    if (start_conv === 1'b1) n_sc++;
    if (out_valid === 1'b1) begin
      last_out <= out_word;
      n_ov++;
    end
  end

  function automatic logic [15:0] mc(input logic [3:0] scan, input logic [3:0] ch, input logic [1:0] rst,
                                      input logic [1:0] pm, input logic tag, input logic sw);
    return {1'b0, scan, ch, rst, pm, tag, sw, 1'b0};
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic clr();
    n_rw = 0;
    n_fc = 0;
    n_sr = 0;
    n_sc = 0;
    n_ov = 0;
  endtask

  task automatic frame(input logic [15:0] w, input int nclk);
    clr();
    @(posedge clk) #1;
    host.send(w, nclk);
    repeat (12) @(posedge clk);
  endtask

  task automatic result(input logic [3:0] ch, input logic [11:0] d, input logic [15:0] exp);
    clr();
    @(posedge clk) #1;
    res_valid = 1'b1;
    res_chan  = ch;
    res_data  = d;
    @(posedge clk) #1;
    res_valid = 1'b0;
    repeat (2) @(posedge clk);
    chk(last_out, exp);
    chk(n_ov, 16'h0001);
  endtask

  task automatic tick(input logic is_scan);
    @(posedge clk) #1;
    if (is_scan) scan_done = 1'b1;
    else conv_done = 1'b1;
    @(posedge clk) #1;
    scan_done = 1'b0;
    conv_done = 1'b0;
  endtask

  task automatic print_verdict();
    if (fails == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    #500000;
    fails++;
    print_verdict();
  end

  initial begin
    rstn = 1'b0; pin_n = 1'b1; int_mode = 1'b0; avg_req = 1'b0; conv_done = 1'b0; scan_done = 1'b0;
    res_valid = 1'b0; res_data = 12'h000; res_chan = 4'h0; fails = 0; num_checks = 0; last_out = 16'h0000;
    clr();
    repeat (2) @(posedge clk) #1;
    rstn = 1'b1;
    repeat (3) @(posedge clk);
    chk(scan_mode, 16'h0001);
    chk(chan_f, 16'h0000);
    chk(pm_f, 16'h0000);
    chk({tag_f, sw_f}, 16'h0000);
    frame(mc(4'h3, 4'h5, 2'h0, 2'h2, 1'b1, 1'b0), 16);
    chk(scan_mode, 16'h0003);
    chk(chan_f, 16'h0005);
    chk(pm_f, 16'h0002);
    chk(tag_f, 16'h0001);
    result(4'ha, 12'h123, 16'ha123);
    frame(mc(4'h0, 4'h9, 2'h0, 2'h1, 1'b0, 1'b0), 16);
    chk({scan_mode, chan_f}, 16'h0035);
    chk({pm_f, tag_f}, 16'h0002);
    result(4'ha, 12'h456, 16'h0456);
    frame({1'b1, 4'h4, 11'h5a5}, 16);
    chk(n_rw, 16'h0001);
    chk({reg_select, 1'b0, reg_data}, {4'h4, 1'b0, 11'h5a5});
    frame({1'b1, 4'hf, 11'h0f0}, 16);
    chk(n_rw, 16'h0000);
    frame(mc(4'h0, 4'h0, 2'h1, 2'h1, 1'b0, 1'b0), 16);
    chk({n_fc[7:0], n_sr[7:0]}, 16'h0100);
    frame(mc(4'h0, 4'h0, 2'h3, 2'h1, 1'b0, 1'b0), 16);
    chk({n_fc[7:0], n_sr[7:0]}, 16'h0000);
    frame(mc(4'h7, 4'h2, 2'h0, 2'h0, 1'b0, 1'b0), 12);
    chk({scan_mode, chan_f}, 16'h0035);
    frame(mc(4'h3, 4'h5, 2'h0, 2'h1, 1'b0, 1'b1), 17);
    chk(n_sc, 16'h0000);
    @(posedge clk) #1;
    int_mode = 1'b1;
    frame(mc(4'h3, 4'h5, 2'h0, 2'h1, 1'b0, 1'b1), 17);
    chk(n_sc, 16'h0001);
    chk(sw_f, 16'h0001);
    tick(1'b0);
    tick(1'b0);
    @(posedge clk);
    chk(scan_channel, 16'h0002);
    tick(1'b1);
    repeat (2) @(posedge clk);
    chk(sw_f, 16'h0000);
    frame(mc(4'h0, 4'h5, 2'h0, 2'h1, 1'b0, 1'b0), 17);
    chk(n_sc, 16'h0000);
    result(4'h7, 12'h9ab, 16'h79ab);
    #1 avg_req = 1'b1;
    repeat (3) @(posedge clk);
    chk(avg_act, 16'h0001);
    #1 int_mode = 1'b0;
    repeat (3) @(posedge clk);
    chk(avg_act, 16'h0000);
    clr();
    @(posedge clk) #1;
    pin_n = 1'b0;
    repeat (2) @(posedge clk) #1;
    pin_n = 1'b1;
    repeat (8) @(posedge clk);
    chk(n_sc, 16'h0001);
    frame(mc(4'h0, 4'h0, 2'h2, 2'h3, 1'b1, 1'b0), 16);
    chk(n_sr, 16'h0001);
    chk({scan_mode, chan_f, 2'h0, pm_f, 2'h0, tag_f, sw_f}, 16'h1000);
    print_verdict();
  end
endmodule
`default_nettype wire
